//--- sar_adc_params.svh
// constants for the converter control and serial readout block
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH
`define CLK_HZ     10000000
`define MS_DIV     1000
`define PWRUP_MS   40
`define CNT_W      20
`define CNT_ONE    20'h00001
`define CAL_CYC    20'h00800
`define BIT_WAIT   20'h00003
`define RES_W      14
`define MSB_IDX    4'hd
`define STOP12     4'h2
`define STOP14     4'h0
`define SH_LEN14   4'hd
`define SH_LEN12   4'hb
`define ACC_W      24
`define ACC_N_W    11
`define ACC_ONE    11'h001
`define LOG2_W     4
`define LOG2_MAX   4'ha
`define SYN_W      9
`define SYN_CNV    0
`define SYN_SCLK   1
`define SYN_COMP   2
`define SYN_RECAL  3
`define SYN_RES12  4
`define SYN_LOG2   5
`define LEN_W      8
`endif

//--- sar_adc_pkg.sv
// types shared by the converter control block
`default_nettype none
`include "sar_adc_params.svh"
package sar_adc_pkg;
   typedef enum logic [2:0] {ST_PWRUP, ST_CAL, ST_STBY, ST_CONV, ST_HOLD} state_t;
   typedef struct packed {
      logic              res12;
      logic [`RES_W-1:0] code;
   } word_t;
endpackage
`default_nettype wire

//--- sar_adc_ctrl.sv
// conversion control, averaging and serial readout of the sar converter
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_params.svh"

// Overview of operation
// - after power-up wait about 40 ms, then self-calibrate offset, gain, linearity
// - once the power-up sequence ends, sit in low-current standby acquiring input
// - a rising edge on convert_start starts a new conversion
// - convert_start low after completion puts the result on serial_data_out
// - conversion is paced by the internal clock, independent of the serial clock
// - a recalibrate command at any time leads to a fresh self-calibration
// - accumulator integrates up to 1024 results and averages them
// - 14-bit or 12-bit results; with averaging off (acc_log2_i of 0), each from the conversion just completed
// - three-wire link with busy indicator; host keeps serial clock below 5 MHz, half the 10 MHz internal clock
module sar_adc_ctrl #(
   parameter int unsigned PWRUP_CYC = `PWRUP_MS * (`CLK_HZ / `MS_DIV)
) (
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              convert_start_i,
   input  wire logic              sclk_i,
   input  wire logic              comp_i,
   input  wire logic              recal_i,
   input  wire logic              res12_i,
   input  wire logic [`LOG2_W-1:0] acc_log2_i,
   output logic      [`RES_W-1:0] dac_o,
   output logic                   busy_o,
   output logic                   acq_o,
   output logic                   serial_data_out_o,
   output logic                   serial_data_out_oe_o
);

   // ==========================================================
   // pin synchronisers
   logic [`SYN_W-1:0] raw;
   wire  [`SYN_W-1:0] syn;
   logic [2:0]        edge_r;

   assign raw = {acc_log2_i, res12_i, recal_i, comp_i, sclk_i, convert_start_i};

   // two flops per pin; first stage feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < `SYN_W; gi = gi + 1) begin : g_sync
         logic s1_r;
         logic s2_r;
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end else begin
               s1_r <= raw[gi];
               s2_r <= s1_r;
            end
         end
         assign syn[gi] = s2_r;
      end
   endgenerate

   // previous synced levels for edge detection
   always_ff @(posedge clock_i) begin
      if (rst_i)
         edge_r <= 3'h0;
      else
         edge_r <= {syn[`SYN_RECAL], syn[`SYN_SCLK], syn[`SYN_CNV]};
   end

   logic              cnv_rise;
   logic              cnv_fall;
   logic              sclk_fall;
   logic              recal_rise;
   logic [`LOG2_W-1:0] log2c;

   // edges of the sampled pins; slow link clock is found by sampling
   assign cnv_rise   = syn[`SYN_CNV] & ~edge_r[0];
   assign cnv_fall   = ~syn[`SYN_CNV] & edge_r[0];
   assign sclk_fall  = ~syn[`SYN_SCLK] & edge_r[1];
   assign recal_rise = syn[`SYN_RECAL] & ~edge_r[2];
   // counts above the limit clamp so the divider stays in range
   assign log2c = (syn[`SYN_LOG2 +: `LOG2_W] > `LOG2_MAX) ? `LOG2_MAX
                : syn[`SYN_LOG2 +: `LOG2_W];

   // ==========================================================
   // conversion control
   sar_adc_pkg::state_t state_r, state_nxt;
   logic [`CNT_W-1:0]   cnt_r, cnt_nxt;
   logic [`LOG2_W-1:0]  bit_r, bit_nxt;
   logic [`RES_W-1:0]   trial_r, trial_nxt;
   logic                res12_r, res12_nxt;
   logic                pend_r, pend_nxt;
   logic [`ACC_W-1:0]   acc_r, acc_nxt;
   logic [`ACC_N_W-1:0] accn_r, accn_nxt;
   sar_adc_pkg::word_t  hold_r, hold_nxt;
   logic                busy_r, busy_nxt;
   logic                acq_r, acq_nxt;
   logic                push_rdy;

   logic [`LOG2_W-1:0]  stop_c;
   logic [`RES_W-1:0]   t_c;
   logic [`RES_W-1:0]   code_fin;
   logic [`ACC_W-1:0]   acc_sum;
   logic [`ACC_N_W-1:0] acc_tgt;

   // bit decision of the current trial and the finished code
   always_comb begin
      stop_c = res12_r ? `STOP12 : `STOP14;
      t_c = trial_r;
      if (!syn[`SYN_COMP])
         t_c[bit_r] = 1'b0;
      if (bit_r != stop_c)
         t_c[bit_r - 1'b1] = 1'b1;
      code_fin = t_c >> stop_c;
      acc_sum  = acc_r + `ACC_W'(code_fin);
      acc_tgt  = `ACC_ONE << log2c;
   end

   // next state of the sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      bit_nxt   = bit_r;
      trial_nxt = trial_r;
      res12_nxt = res12_r;
      pend_nxt  = pend_r | recal_rise;  // a new request beats the clear
      acc_nxt   = acc_r;
      accn_nxt  = accn_r;
      hold_nxt  = hold_r;
      case (state_r)
         sar_adc_pkg::ST_PWRUP: begin
            res12_nxt = syn[`SYN_RES12];  // variant strap caught after reset
            if (cnt_r == '0) begin
               state_nxt = sar_adc_pkg::ST_CAL;
               cnt_nxt   = `CAL_CYC - `CNT_ONE;
               pend_nxt  = recal_rise;
            end else begin
               cnt_nxt = cnt_r - `CNT_ONE;
            end
         end
         sar_adc_pkg::ST_CAL: begin
            if (cnt_r == '0)
               state_nxt = sar_adc_pkg::ST_STBY;
            else
               cnt_nxt = cnt_r - `CNT_ONE;
         end
         sar_adc_pkg::ST_STBY: begin
            if (pend_r) begin
               state_nxt = sar_adc_pkg::ST_CAL;
               cnt_nxt   = `CAL_CYC - `CNT_ONE;
               pend_nxt  = recal_rise;
               acc_nxt   = '0;
               accn_nxt  = '0;
            end else if (cnv_rise) begin
               state_nxt = sar_adc_pkg::ST_CONV;
               bit_nxt   = `MSB_IDX;
               trial_nxt = '0;
               trial_nxt[`MSB_IDX] = 1'b1;
               cnt_nxt   = `BIT_WAIT;
            end
         end
         sar_adc_pkg::ST_CONV: begin
            // paced only by clock_i; serial clock plays no part
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - `CNT_ONE;
            end else begin
               trial_nxt = t_c;
               cnt_nxt   = `BIT_WAIT;
               if (bit_r != stop_c) begin
                  bit_nxt = bit_r - 1'b1;
               end else if (accn_r + 1'b1 >= acc_tgt) begin
                  hold_nxt.res12 = res12_r;
                  hold_nxt.code  = `RES_W'(acc_sum >> log2c);
                  acc_nxt   = '0;
                  accn_nxt  = '0;
                  state_nxt = sar_adc_pkg::ST_HOLD;
               end else begin
                  acc_nxt   = acc_sum;
                  accn_nxt  = accn_r + 1'b1;
                  state_nxt = sar_adc_pkg::ST_STBY;
               end
            end
         end
         sar_adc_pkg::ST_HOLD: begin
            // waits here while the buffer is full so no word is lost
            if (push_rdy)
               state_nxt = sar_adc_pkg::ST_STBY;
         end
         default: state_nxt = sar_adc_pkg::ST_PWRUP;
      endcase
      busy_nxt = state_nxt != sar_adc_pkg::ST_STBY;
      acq_nxt  = state_nxt == sar_adc_pkg::ST_STBY;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_r <= sar_adc_pkg::ST_PWRUP;
         cnt_r   <= `CNT_W'(PWRUP_CYC) - `CNT_ONE;
         bit_r   <= '0;
         trial_r <= '0;
         res12_r <= 1'b0;
         pend_r  <= 1'b0;
         acc_r   <= '0;
         accn_r  <= '0;
         hold_r  <= '0;
         busy_r  <= 1'b1;
         acq_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         bit_r   <= bit_nxt;
         trial_r <= trial_nxt;
         res12_r <= res12_nxt;
         pend_r  <= pend_nxt;
         acc_r   <= acc_nxt;
         accn_r  <= accn_nxt;
         hold_r  <= hold_nxt;
         busy_r  <= busy_nxt;
         acq_r   <= acq_nxt;
      end
   end

   // ==========================================================
   // two-entry result buffer
   sar_adc_pkg::word_t buf_r [2];
   sar_adc_pkg::word_t buf_nxt [2];
   logic       wp_r, wp_nxt, rp_r, rp_nxt;
   logic [1:0] fill_r, fill_nxt;
   logic       push, pop;

   assign push_rdy = fill_r != 2'h2;
   assign push     = (state_r == sar_adc_pkg::ST_HOLD) & push_rdy;
   // drained when the host lowers convert_start
   assign pop      = cnv_fall & (fill_r != 2'h0);

   always_comb begin
      buf_nxt  = buf_r;
      wp_nxt   = wp_r;
      rp_nxt   = rp_r;
      fill_nxt = fill_r;
      if (push) begin
         buf_nxt[wp_r] = hold_r;
         wp_nxt = ~wp_r;
      end
      if (pop)
         rp_nxt = ~rp_r;
      if (push & ~pop)
         fill_nxt = fill_r + 2'h1;
      else if (pop & ~push)
         fill_nxt = fill_r - 2'h1;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         buf_r  <= '{default: '0};
         wp_r   <= 1'b0;
         rp_r   <= 1'b0;
         fill_r <= 2'h0;
      end else begin
         buf_r  <= buf_nxt;
         wp_r   <= wp_nxt;
         rp_r   <= rp_nxt;
         fill_r <= fill_nxt;
      end
   end

   // ==========================================================
   // serial shifter
   logic [`RES_W-1:0]  sh_r, sh_nxt;
   logic [`LOG2_W-1:0] left_r, left_nxt;
   logic               sdo_r, sdo_nxt;
   logic               oe_r, oe_nxt;
   logic [`RES_W-1:0]  head_al;

   // left-align the 12-bit word so the msb always sits on top
   assign head_al = buf_r[rp_r].res12 ? (buf_r[rp_r].code << `STOP12)
                  : buf_r[rp_r].code;

   always_comb begin
      sh_nxt   = sh_r;
      left_nxt = left_r;
      sdo_nxt  = sdo_r;
      oe_nxt   = oe_r;
      if (pop) begin
         sh_nxt   = head_al;
         sdo_nxt  = head_al[`RES_W-1];
         left_nxt = buf_r[rp_r].res12 ? `SH_LEN12 : `SH_LEN14;
         oe_nxt   = 1'b1;
      end else if (sclk_fall && acq_r && oe_r && left_r != '0) begin
         sh_nxt   = sh_r << 1;
         sdo_nxt  = sh_r[`RES_W-2];
         left_nxt = left_r - 1'b1;
      end
      if (cnv_rise)
         oe_nxt = 1'b0;  // line released while converting
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sh_r   <= '0;
         left_r <= '0;
         sdo_r  <= 1'b0;
         oe_r   <= 1'b0;
      end else begin
         sh_r   <= sh_nxt;
         left_r <= left_nxt;
         sdo_r  <= sdo_nxt;
         oe_r   <= oe_nxt;
      end
   end

   assign dac_o                = trial_r;
   assign busy_o               = busy_r;
   assign acq_o                = acq_r;
   assign serial_data_out_o    = sdo_r;
   assign serial_data_out_oe_o = oe_r;

   // ==========================================================
   // checks
   logic [`CNT_W-1:0] up_cnt_r;
   logic [`LEN_W-1:0] len_r;

   // helper counters: power-up dwell and conversion length
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         up_cnt_r <= '0;
         len_r    <= '0;
      end else begin
         if (state_r == sar_adc_pkg::ST_PWRUP)
            up_cnt_r <= up_cnt_r + `CNT_ONE;
         len_r <= (state_r == sar_adc_pkg::ST_CONV) ? len_r + 1'b1 : '0;
      end
   end

   property p_pwrup;
      @(posedge clock_i) disable iff (rst_i)
      $fell(state_r == sar_adc_pkg::ST_PWRUP) |->
         up_cnt_r == `CNT_W'(PWRUP_CYC) && state_r == sar_adc_pkg::ST_CAL;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("power-up wait wrong");

   property p_stby;
      @(posedge clock_i) disable iff (rst_i)
      (state_r == sar_adc_pkg::ST_CAL && cnt_r == '0) |=>
         state_r == sar_adc_pkg::ST_STBY && acq_o && !busy_o;
   endproperty
   a_stby: assert property (p_stby) else $error("no standby after cal");

   property p_start;
      @(posedge clock_i) disable iff (rst_i)
      (state_r == sar_adc_pkg::ST_STBY && cnv_rise && !pend_r) |=>
         state_r == sar_adc_pkg::ST_CONV && busy_o && dac_o[`RES_W-1];
   endproperty
   a_start: assert property (p_start) else $error("start edge missed");

   property p_present;
      @(posedge clock_i) disable iff (rst_i)
      pop |=> serial_data_out_oe_o && serial_data_out_o == $past(head_al[`RES_W-1]);
   endproperty
   a_present: assert property (p_present) else $error("result not shown");

   property p_pace;
      @(posedge clock_i) disable iff (rst_i)
      $fell(state_r == sar_adc_pkg::ST_CONV) |->
         int'(len_r) == (int'(`MSB_IDX) - int'(stop_c) + 1) * (int'(`BIT_WAIT) + 1);
   endproperty
   a_pace: assert property (p_pace) else $error("conversion length wrong");

   property p_recal;
      @(posedge clock_i) disable iff (rst_i)
      (state_r == sar_adc_pkg::ST_STBY && pend_r) |=>
         state_r == sar_adc_pkg::ST_CAL ##1 busy_o;
   endproperty
   a_recal: assert property (p_recal) else $error("recal ignored");

   property p_accum;
      @(posedge clock_i) disable iff (rst_i)
      state_r == sar_adc_pkg::ST_STBY |-> accn_r < acc_tgt || log2c != $past(log2c);
   endproperty
   a_accum: assert property (p_accum) else $error("accumulator overrun");

   property p_nolat;
      @(posedge clock_i) disable iff (rst_i)
      (state_r == sar_adc_pkg::ST_CONV && cnt_r == '0 && bit_r == stop_c
         && acc_tgt == `ACC_ONE) |=>
         state_r == sar_adc_pkg::ST_HOLD && hold_r.code == $past(code_fin);
   endproperty
   a_nolat: assert property (p_nolat) else $error("stale result");

   property p_busy;
      @(posedge clock_i) disable iff (rst_i)
      busy_o != (state_r == sar_adc_pkg::ST_STBY);
   endproperty
   a_busy: assert property (p_busy) else $error("busy flag wrong");

   property p_shift;
      @(posedge clock_i) disable iff (rst_i)
      (!pop && sclk_fall && acq_r && oe_r && left_r != '0) |=>
         serial_data_out_o == $past(sh_r[`RES_W-2]) && left_r == $past(left_r) - 1'b1;
   endproperty
   a_shift: assert property (p_shift) else $error("bad shift");

endmodule
`default_nettype wire

//--- sar_host_model.sv
// host-side model: drives the convert-start pin and the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_params.svh"
module sar_host_model (
   input  wire logic clock_i,
   input  wire logic serial_data_i,
   output logic      convert_start_o,
   output logic      sclk_o
);
   // =========================================
   // pins
   // both pins idle low; the serial clock stands still outside frames
   initial begin
      convert_start_o = 1'b0;
      sclk_o          = 1'b0;
   end
   // rising edge starts a conversion; the caller keeps starts spaced
   task automatic conv_rise();
      @(posedge clock_i);
      #5 convert_start_o = 1'b1;
   endtask
   // lowering the pin after completion asks for the word
   task automatic conv_fall();
      @(posedge clock_i);
      #5 convert_start_o = 1'b0;
   endtask
   // 800 ns serial clock, far below the link ceiling; sample on the rise
   task automatic shift(input int n, output logic [`RES_W-1:0] w);
      w = '0;
      #37;
      for (int i = 0; i < n; i++) begin
         sclk_o = 1'b1;
         w = {w[`RES_W-2:0], serial_data_i};
         #400 sclk_o = 1'b0;
         #400;
      end
   endtask
endmodule
`default_nettype wire

//--- sar_adc_conversion_serial_readout_tb_top.sv
// self-checking bench for the converter control and serial readout block
`timescale 1ns/10ps
`default_nettype none
`include "sar_adc_params.svh"
module sar_adc_conversion_serial_readout_tb_top;
   // =========================================
   // signals
   localparam int unsigned PWRUP = 20; // short power-up wait keeps the run brief
   logic               clock_i     = 1'b0;
   logic               rst_i       = 1'b1;
   logic               recal_i     = 1'b0;
   logic               res12_i     = 1'b0;
   logic [`LOG2_W-1:0] acc_log2_i  = '0;
   logic [`RES_W-1:0]  vin         = '0;
   logic [`RES_W-1:0]  dac_o;
   logic [`RES_W-1:0]  got;
   logic               busy_o;
   logic               acq_o;
   logic               serial_data_out;
   logic               sdo_oe;
   logic               cnv;
   logic               sclk;
   logic               comp_i;
   int                 bad_count   = 0;
   int                 checks_done = 0;
   int                 n;

   // =========================================
   // clock, comparator and instances
   always #50 clock_i = ~clock_i;
   // comparator: high while the input is at or above the trial code
   assign comp_i = (dac_o <= vin);

   sar_adc_ctrl #(.PWRUP_CYC(PWRUP)) DUT (
      .clock_i             (clock_i),
      .rst_i               (rst_i),
      .convert_start_i     (cnv),
      .sclk_i              (sclk),
      .comp_i              (comp_i),
      .recal_i             (recal_i),
      .res12_i             (res12_i),
      .acc_log2_i          (acc_log2_i),
      .dac_o               (dac_o),
      .busy_o              (busy_o),
      .acq_o               (acq_o),
      .serial_data_out_o   (serial_data_out),
      .serial_data_out_oe_o(sdo_oe)
   );
   sar_host_model host (
      .clock_i        (clock_i),
      .serial_data_i  (serial_data_out),
      .convert_start_o(cnv),
      .sclk_o         (sclk)
   );

   // =========================================
   // helpers
   task automatic check(string what, logic [15:0] exp, logic [15:0] seen);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // step k clock edges, landing just after the last one
   task automatic cycles(int k);
      repeat (k) @(posedge clock_i);
      #5;
   endtask
   // bounded wait for busy to reach a level; n holds the cycles spent
   task automatic wait_busy(logic lvl, int lim);
      n = 0;
      while (busy_o !== lvl) begin
         cycles(1);
         n++;
         if (n > lim) begin
            $display("FAIL busy wait expected %h seen %h", lvl, busy_o);
            bad_count++;
            close_out();
         end
      end
   endtask
   // reset with a variant strap, then time power-up plus calibration
   task automatic do_reset(logic r12);
      @(posedge clock_i);
      #5 rst_i = 1'b1;
      res12_i = r12;
      cycles(6);
      check("reset busy", 16'h1, busy_o);
      check("reset acq", 16'h0, acq_o);
      check("reset dac", 16'h0, dac_o);
      check("reset oe", 16'h0, sdo_oe);
      rst_i = 1'b0;
      wait_busy(1'b0, 3000);
      check("powerup length", 16'h1, 16'(n >= PWRUP + 2046 && n <= PWRUP + 2054));
      check("standby acq", 16'h1, acq_o);
   endtask
   // one conversion; done=0 returns while the conversion is still running
   task automatic convert(logic [`RES_W-1:0] v, logic done);
      int len;
      len = (res12_i ? 12 : 14) * 4;
      vin = v;
      cycles(10);
      host.conv_rise();
      cycles(5);
      check("conv busy", 16'h1, busy_o);
      check("conv acq", 16'h0, acq_o);
      if (done) begin
         wait_busy(1'b0, 80);
         check("conv length", 16'h1, 16'(n >= len - 4 && n <= len + 4));
      end
   endtask
   // lower the pin and shift a word out
   task automatic read_word(int bits, logic [`RES_W-1:0] exp);
      host.conv_fall();
      cycles(5);
      check("data enable", 16'h1, sdo_oe);
      host.shift(bits, got);
      check("word", exp, got);
      cycles(1); // back onto the stimulus grid after the delay-timed link clock
   endtask

   // =========================================
   // scenarios
   task automatic t_single();
      convert(14'h2a5c, 1'b1);
      read_word(14, 14'h2a5c);
      $display("test single done");
   endtask
   // two results averaged into one word, the first gives no word
   task automatic t_average();
      acc_log2_i = 4'h1;
      convert(14'h1000, 1'b1);
      host.conv_fall();
      cycles(5);
      check("no word yet", 16'h0, sdo_oe);
      convert(14'h1003, 1'b1);
      read_word(14, 14'h1001);
      acc_log2_i = 4'h0;
      $display("test average done");
   endtask
   // a fall on an empty buffer pops nothing; two words then wait, oldest leaves first
   task automatic t_buffer();
      convert(14'h0111, 1'b0);
      host.conv_fall();
      wait_busy(1'b0, 80);
      check("early fall no word", 16'h0, sdo_oe);
      convert(14'h0222, 1'b1);
      check("two held acq", 16'h1, acq_o);
      read_word(14, 14'h0111);
      convert(14'h0333, 1'b1);
      check("third held acq", 16'h1, acq_o);
      read_word(14, 14'h0222);
      $display("test buffer done");
   endtask
   // recalibrate request gives a fresh calibration
   task automatic t_recal();
      recal_i = 1'b1;
      cycles(3);
      recal_i = 1'b0;
      wait_busy(1'b1, 20);
      wait_busy(1'b0, 2200);
      check("recal length", 16'h1, 16'(n >= 2040 && n <= 2052));
      $display("test recal done");
   endtask
   // short variant: twelve bits leave the line
   task automatic t_res12();
      do_reset(1'b1);
      convert(14'h3fff, 1'b1);
      read_word(12, 14'h0fff);
      $display("test res12 done");
   endtask

   // =========================================
   // main sequence and watchdog
   initial begin
      do_reset(1'b0);
      t_single();
      t_average();
      t_buffer();
      t_recal();
      t_res12();
      close_out();
   end
   // a hang counts as a mismatch and ends the run
   initial begin
      cycles(60000);
      $display("FAIL watchdog expected %h seen %h", 1'b0, 1'b1);
      bad_count++;
      close_out();
   end
endmodule
`default_nettype wire
